/* include/lss_pkg.sv */
// Shared constants and types for the LED driver startup sequencer.
package lss_pkg;

	localparam int unsigned CLK_HZ      = 40_000_000;
	localparam int unsigned HZ_PER_MHZ  = 1_000_000;
	localparam int unsigned CYC_PER_US  = CLK_HZ / HZ_PER_MHZ;
	localparam int unsigned CHANNELS    = 4;
	localparam int unsigned TMR_W       = 20;
	localparam int unsigned RAMP_W      = 8;

	// Times in microseconds, counts in clock cycles.
	localparam int unsigned SHUTDOWN_US = 16000;
	localparam int unsigned DETECT_US   = 1500;
	localparam int unsigned SS_BASE_US  = 8000;
	localparam int unsigned SS_EXT_US   = 16000;
	localparam int unsigned SHUTDOWN_CYC = SHUTDOWN_US * CYC_PER_US;
	localparam int unsigned DETECT_CYC   = DETECT_US * CYC_PER_US;
	localparam int unsigned SS_BASE_CYC  = SS_BASE_US * CYC_PER_US;
	localparam int unsigned SS_EXT_CYC   = SS_EXT_US * CYC_PER_US;

	typedef enum logic [2:0] {
		LSS_LOCKOUT,
		LSS_GATE_ON,
		LSS_WAIT_PWM,
		LSS_DETECT,
		LSS_SOFT_START,
		LSS_RUN,
		LSS_LATCHED
	} lss_state_e;

	// Comparator and pin levels, all from outside the clock domain.
	typedef struct packed {
		logic                wake;
		logic                pwm;
		logic                supply_ok;
		logic                gate_on;
		logic                freq_pin_ok;
		logic                cur_pin_ok;
		logic                out_uvp_ok;
		logic                out_near_ovp;
		logic [CHANNELS-1:0] above_low;
		logic [CHANNELS-1:0] above_high;
		logic [CHANNELS-1:0] in_regulation;
		logic                extended;
	} lss_sense_s;

	typedef struct packed {
		lss_state_e          state;
		logic                variant_ext;
		logic                fault;
		logic                counting;
		logic [CHANNELS-1:0] used;
		logic [CHANNELS-1:0] unused;
		logic [TMR_W-1:0]    tmr;
		logic [TMR_W-1:0]    wake_low;
		logic [TMR_W-1:0]    pwm_low;
		logic [TMR_W-1:0]    step;
		logic [RAMP_W-1:0]   ramp;
	} lss_regs_s;

endpackage : lss_pkg

/* hdl/lss_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/10ps
module lss_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clock, // System clock.
	input  wire logic         rst,   // Asynchronous reset, active high.
	input  wire logic [W-1:0] d,     // Asynchronous levels.
	output logic      [W-1:0] q      // Synchronised levels.
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : lss_sync

/* hdl/lss_sequencer.sv */
// Startup and fault sequencer of a multi-string LED boost driver.
`timescale 1ns/10ps
// How it works
// RULE1: Power up only with wake high and input supply above lockout.
// RULE2: Boost and sinks stay off until PWM is high.
// RULE3: Frequency and current pins must pass before switching starts.
// RULE4: Wake low longer than the shutdown delay turns the device off.
// RULE5: Host may toggle PWM for dimming or tie it to wake.
// RULE6: Pull disconnect gate first; at on level enable current reference.
// RULE7: Detection starts only with PWM high and gate at on level.
// RULE8: After pins pass the low threshold, wait the detection interval.
// RULE9: Each pin is classed as shorted, unused or in use by voltage.
// RULE10: Unused channels are disabled and dropped from feedback.
// RULE11: A shorted pin holds soft-start until the short clears.
// RULE12: Base variant flags a pin short and keeps retrying.
// RULE13: Base variant releases the flag at detection end.
// RULE14: Extended variant releases the flag at detection start.
// RULE15: Output below the undervoltage level after gate-on blocks soft-start.
// RULE16: Output undervoltage latches the device off.
// RULE17: Latch clears on lockout, long wake low, or long PWM low.
// RULE18: Soft-start begins after detection and ramps at a fixed slope.
// RULE19: Soft-start timer is eight or sixteen milliseconds by variant.
// RULE20: Soft-start ends on regulation, output near limit, or timer.
// RULE21: Clock mirror runs once awake, even with boost off.
// RULE22: Ramp time limit follows the variant timer.
// RULE23: Sequencer walks lockout to run, with a latched-off state.
module lss_sequencer #(
	parameter int unsigned SHUTDOWN_CYC = lss_pkg::SHUTDOWN_CYC,
	parameter int unsigned DETECT_CYC   = lss_pkg::DETECT_CYC,
	parameter int unsigned SS_BASE_CYC  = lss_pkg::SS_BASE_CYC,
	parameter int unsigned SS_EXT_CYC   = lss_pkg::SS_EXT_CYC
) (
	input  wire logic                               clock,               // 40 MHz oscillator clock.
	input  wire logic                               rst,                 // Asynchronous reset, high.
	input  wire lss_pkg::lss_sense_s                sense_in,            // Raw pin and comparator levels.
	output logic                                    clock_mirror_output, // Clock mirror enable.
	output logic                                    gate_pull_down,      // Disconnect gate pull-down.
	output logic                                    current_ref_enable,  // Current reference enable.
	output logic                                    boost_enable,        // Boost switching enable.
	output logic [lss_pkg::CHANNELS-1:0]            sink_enable,         // String sink enables.
	output logic [lss_pkg::CHANNELS-1:0]            feedback_mask,       // Channels in regulation feedback.
	output logic [lss_pkg::RAMP_W-1:0]              ramp_level,          // Soft-start output reference.
	output logic                                    soft_start_active,   // Soft-start in progress.
	output logic                                    fault_o,             // Fault flag pin output level.
	output logic                                    fault_oe,            // Fault flag pin drive enable.
	output lss_pkg::lss_state_e                     state_out            // Sequencer state.
);

	localparam int unsigned TW = lss_pkg::TMR_W;
	localparam int unsigned RW = lss_pkg::RAMP_W;
	localparam logic [TW-1:0] SHUT_MAX = TW'(SHUTDOWN_CYC);
	localparam logic [TW-1:0] DET_LAST = TW'(DETECT_CYC - 1);
	localparam logic [TW-1:0] SS_BASE_LAST = TW'(SS_BASE_CYC - 1);
	localparam logic [TW-1:0] SS_EXT_LAST = TW'(SS_EXT_CYC - 1);
	localparam logic [TW-1:0] STEP_BASE_LAST = TW'((SS_BASE_CYC >> RW) - 1);
	localparam logic [TW-1:0] STEP_EXT_LAST = TW'((SS_EXT_CYC >> RW) - 1);
	localparam logic [TW-1:0] TMR_ONE = TW'(1);
	localparam logic [RW-1:0] RAMP_ONE = RW'(1);
	localparam logic [RW-1:0] RAMP_TOP = '1;

	lss_pkg::lss_sense_s s;
	lss_pkg::lss_regs_s  r_r;
	lss_pkg::lss_regs_s  r_nxt;
	logic                any_short;
	logic                pins_ok;
	logic                wake_off;
	logic                pwm_off;
	logic                ss_done;
	logic                active;
	logic [TW-1:0]       ss_last;
	logic [TW-1:0]       step_last;

	function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v, input logic run);
		if (!run) begin
			return '0;
		end
		return (v == SHUT_MAX) ? v : v + TMR_ONE;
	endfunction : sat_inc

	lss_sync #(
		.W ($bits(lss_pkg::lss_sense_s))
	) u_sync (
		.clock (clock),
		.rst   (rst),
		.d     (sense_in),
		.q     (s)
	);

	// Pins below the low threshold count as shorted to ground.
	assign any_short = |(~s.above_low);
	// RULE3: resistor pin checks
	assign pins_ok   = s.freq_pin_ok && s.cur_pin_ok;
	assign wake_off  = (r_r.wake_low == SHUT_MAX);
	assign pwm_off   = (r_r.pwm_low == SHUT_MAX);
	assign ss_last   = r_r.variant_ext ? SS_EXT_LAST : SS_BASE_LAST;
	assign step_last = r_r.variant_ext ? STEP_EXT_LAST : STEP_BASE_LAST;
	// RULE20: soft-start end events
	assign ss_done = (&(s.in_regulation | ~r_r.used)) || s.out_near_ovp || (r_r.tmr == ss_last);

	always_comb begin
		r_nxt = r_r;
		r_nxt.wake_low = sat_inc(r_r.wake_low, !s.wake);
		r_nxt.pwm_low  = sat_inc(r_r.pwm_low, s.wake && !s.pwm);
		// RULE23: sequencer state walk
		unique case (r_r.state)
			lss_pkg::LSS_LOCKOUT: begin
				r_nxt.fault = 1'b0;
				r_nxt.tmr   = '0;
				// RULE1: wake needs supply
				if (s.wake && s.supply_ok) begin
					r_nxt.variant_ext = s.extended;
					r_nxt.state       = lss_pkg::LSS_GATE_ON;
				end
			end
			lss_pkg::LSS_GATE_ON: begin
				// RULE6: gate reaches on level
				if (s.gate_on) begin
					r_nxt.state = lss_pkg::LSS_WAIT_PWM;
				end
			end
			lss_pkg::LSS_WAIT_PWM: begin
				// RULE7: PWM and gate gate detection
				if (s.pwm && s.gate_on) begin
					r_nxt.state    = lss_pkg::LSS_DETECT;
					r_nxt.counting = 1'b0;
					r_nxt.tmr      = '0;
				end
			end
			lss_pkg::LSS_DETECT: begin
				if (any_short || !pins_ok) begin
					// RULE11: hold on short
					r_nxt.counting = 1'b0;
					r_nxt.tmr      = '0;
					// RULE12: flag and retry
					r_nxt.fault    = any_short;
				end else begin
					r_nxt.counting = 1'b1;
					// RULE14: early flag release
					if (!r_r.counting && r_r.variant_ext) begin
						r_nxt.fault = 1'b0;
					end
					// RULE8: detection interval wait
					if (r_r.tmr == DET_LAST) begin
						// RULE9: classify by threshold
						r_nxt.used   = s.above_high;
						r_nxt.unused = ~s.above_high;
						r_nxt.tmr    = '0;
						r_nxt.step   = '0;
						r_nxt.ramp   = '0;
						// RULE13: late flag release
						if (!r_r.variant_ext) begin
							r_nxt.fault = 1'b0;
						end
						// RULE15: output undervoltage check
						if (!s.out_uvp_ok) begin
							r_nxt.state = lss_pkg::LSS_LATCHED;
							r_nxt.fault = 1'b1;
						end else begin
							r_nxt.state = lss_pkg::LSS_SOFT_START;
						end
					end else begin
						r_nxt.tmr = r_r.tmr + TMR_ONE;
					end
				end
			end
			lss_pkg::LSS_SOFT_START: begin
				// RULE19: variant timer
				r_nxt.tmr = r_r.tmr + TMR_ONE;
				// RULE18: fixed slope ramp
				if (r_r.step == step_last) begin
					r_nxt.step = '0;
					if (r_r.ramp != RAMP_TOP) begin
						r_nxt.ramp = r_r.ramp + RAMP_ONE;
					end
				end else begin
					r_nxt.step = r_r.step + TMR_ONE;
				end
				if (ss_done) begin
					r_nxt.state = lss_pkg::LSS_RUN;
					r_nxt.ramp  = RAMP_TOP;
				end
			end
			lss_pkg::LSS_RUN: begin
				r_nxt.tmr = '0;
			end
			lss_pkg::LSS_LATCHED: begin
				// RULE16: stay latched off
				r_nxt.fault = 1'b1;
				// RULE17: long PWM low clears
				if (pwm_off) begin
					r_nxt.fault = 1'b0;
					r_nxt.state = lss_pkg::LSS_GATE_ON;
				end
			end
			default: begin
				r_nxt.state = lss_pkg::LSS_LOCKOUT;
			end
		endcase
		// RULE4: long wake low or lockout
		if (!s.supply_ok || wake_off) begin
			r_nxt.state = lss_pkg::LSS_LOCKOUT;
			r_nxt.fault = 1'b0;
			r_nxt.used  = '0;
			r_nxt.ramp  = '0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign active = (r_r.state == lss_pkg::LSS_SOFT_START) || (r_r.state == lss_pkg::LSS_RUN);
	// RULE21: clock mirror while awake
	assign clock_mirror_output = (r_r.state != lss_pkg::LSS_LOCKOUT);
	assign gate_pull_down      = (r_r.state != lss_pkg::LSS_LOCKOUT) && (r_r.state != lss_pkg::LSS_LATCHED);
	assign current_ref_enable  = gate_pull_down && (r_r.state != lss_pkg::LSS_GATE_ON);
	// RULE2: PWM enables the power stage
	assign boost_enable        = active && s.pwm;
	// RULE10: unused channels off
	assign sink_enable         = r_r.used & {lss_pkg::CHANNELS{boost_enable}};
	assign feedback_mask       = r_r.used;
	assign ramp_level          = r_r.ramp;
	assign soft_start_active   = (r_r.state == lss_pkg::LSS_SOFT_START);
	assign fault_o             = 1'b0;
	assign fault_oe            = r_r.fault;
	assign state_out           = r_r.state;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	chk_supply_lockout: assert property (!s.supply_ok |=> r_r.state == lss_pkg::LSS_LOCKOUT) // RULE1
		else $error("state left lockout without supply");
	chk_boost_pwm: assert property (boost_enable |-> s.pwm && active) // RULE2
		else $error("boost enabled without PWM");
	chk_wake_shutdown: assert property (wake_off |=> r_r.state == lss_pkg::LSS_LOCKOUT) // RULE4
		else $error("long wake low did not shut down");
	chk_detect_entry: assert property ($rose(r_r.state == lss_pkg::LSS_DETECT) |-> $past(s.pwm && s.gate_on)) // RULE7
		else $error("detection began without PWM and gate");
	chk_ss_entry: assert property ($rose(soft_start_active) |-> $past(r_r.tmr) == DET_LAST) // RULE18
		else $error("soft-start before detection interval");
	chk_short_hold: assert property (r_r.state == lss_pkg::LSS_DETECT && any_short && s.supply_ok && !wake_off
		|=> r_r.state == lss_pkg::LSS_DETECT && r_r.tmr == '0 && fault_oe) // RULE11
		else $error("short did not hold detection");
	chk_uvp_latch: assert property ($rose(r_r.state == lss_pkg::LSS_LATCHED) |-> $past(!s.out_uvp_ok)
		&& fault_oe) // RULE16
		else $error("latch without output undervoltage");
	chk_latch_stay: assert property (r_r.state == lss_pkg::LSS_LATCHED && s.supply_ok && !wake_off && !pwm_off
		|=> r_r.state == lss_pkg::LSS_LATCHED) // RULE17
		else $error("latch cleared early");
	chk_unused_off: assert property (active |-> (sink_enable & r_r.unused) == '0) // RULE10
		else $error("unused channel enabled");
	chk_ss_limit: assert property (soft_start_active |-> r_r.tmr <= ss_last) // RULE22
		else $error("soft-start ran past timer");
	chk_mirror_awake: assert property ($rose(r_r.state == lss_pkg::LSS_GATE_ON) |-> clock_mirror_output
		&& !boost_enable) // RULE21
		else $error("clock mirror off after wake");

	cov_run: cover property ($rose(r_r.state == lss_pkg::LSS_RUN));
	cov_latch: cover property ($rose(r_r.state == lss_pkg::LSS_LATCHED));
	cov_short_clear: cover property (r_r.state == lss_pkg::LSS_DETECT && fault_oe ##1 !fault_oe);

endmodule : lss_sequencer

/* verif/lss_host_model.sv */
// Host controller model that drives the wake and dimming pins of the sequencer.
`timescale 1ns/10ps
module lss_host_model (
	input  wire logic want_wake, // Requested wake level.
	input  wire logic want_pwm,  // Requested dimming level.
	input  wire logic tie_pins,  // Single-wire mode, dimming pin follows wake.
	output logic      wake,      // Wake pin.
	output logic      pwm        // Dimming pin.
);
	// dimming pin follows wake when pins are tied, else the requested dimming level
	assign wake = want_wake;
	assign pwm  = tie_pins ? want_wake : want_pwm;
endmodule : lss_host_model

/* verif/test_led_driver_startup_sequencer.sv */
// Self-checking testbench of the LED driver startup sequencer.
`timescale 1ns/10ps
module test_led_driver_startup_sequencer;
	localparam int unsigned SD = 40, DT = 20, SSB = 512, SSE = 1024;
	typedef struct packed {
		logic [3:0]          in;
		lss_pkg::lss_state_e st;
		logic [2:0]          outs;
	} lss_row_s;
	logic                               clock, rst, want_wake, want_pwm, tie_pins, wake, pwm;
	logic                               mirror, pull, cref, boost, ssa, f_o, f_oe;
	logic [lss_pkg::CHANNELS-1:0]       sink, fbm;
	logic [lss_pkg::RAMP_W-1:0]         ramp;
	lss_pkg::lss_state_e                state_out;
	lss_pkg::lss_sense_s                s_tb, sense;
	int                                 fails = 0, samples_checked = 0, n;
	lss_row_s                           rows [6];

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always_comb begin
		sense      = s_tb;
		sense.wake = wake;
		sense.pwm  = pwm;
	end
	lss_host_model host (.want_wake(want_wake), .want_pwm(want_pwm), .tie_pins(tie_pins), .wake(wake), .pwm(pwm));
	lss_sequencer #(.SHUTDOWN_CYC(SD), .DETECT_CYC(DT), .SS_BASE_CYC(SSB), .SS_EXT_CYC(SSE)) uut (
		.clock(clock), .rst(rst), .sense_in(sense), .clock_mirror_output(mirror), .gate_pull_down(pull),
		.current_ref_enable(cref), .boost_enable(boost), .sink_enable(sink), .feedback_mask(fbm),
		.ramp_level(ramp), .soft_start_active(ssa), .fault_o(f_o), .fault_oe(f_oe), .state_out(state_out));

	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task complete_run;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	task wait_st(input lss_pkg::lss_state_e st, input int lim, output int k);
		k = 0;
		while (state_out !== st && k < lim) begin
			@(negedge clock);
			k++;
		end
		chk("state", 16'(st), 16'(state_out));
	endtask : wait_st
	task do_reset;
		rst       = 1'b1;
		want_wake = 1'b0;
		want_pwm  = 1'b0;
		tie_pins  = 1'b0;
		s_tb      = '0;
		s_tb.supply_ok = 1'b1;
		s_tb.freq_pin_ok = 1'b1;
		s_tb.cur_pin_ok = 1'b1;
		s_tb.out_uvp_ok = 1'b1;
		s_tb.above_low = 4'hf;
		s_tb.above_high = 4'hf;
		repeat (4) @(negedge clock);
		chk("reset_outs", 16'h0, 16'({mirror, pull, cref, boost, f_oe, state_out}));
		rst = 1'b0;
	endtask : do_reset
	// The extended variant starts in single-wire mode.
	task bring_up(input logic ext);
		do_reset();
		s_tb.extended = ext;
		tie_pins = ext;
		want_wake = 1'b1;
		wait_st(lss_pkg::LSS_GATE_ON, 10, n);
		s_tb.gate_on = 1'b1;
		want_pwm = 1'b1;
		wait_st(lss_pkg::LSS_DETECT, 12, n);
	endtask : bring_up

	initial begin
		#(25ns * 30000);
		fails++;
		complete_run();
	end

	initial begin
		rows[0] = {4'b1000, lss_pkg::LSS_LOCKOUT, 3'b000};
		rows[1] = {4'b0100, lss_pkg::LSS_LOCKOUT, 3'b000};
		rows[2] = {4'b1100, lss_pkg::LSS_GATE_ON, 3'b110};
		rows[3] = {4'b1101, lss_pkg::LSS_GATE_ON, 3'b110};
		rows[4] = {4'b1110, lss_pkg::LSS_WAIT_PWM, 3'b111};
		rows[5] = {4'b1111, lss_pkg::LSS_DETECT, 3'b111};
		do_reset();
		s_tb.above_high = 4'b0011;
		foreach (rows[i]) begin
			want_wake = rows[i].in[3];
			s_tb.supply_ok = rows[i].in[2];
			s_tb.gate_on = rows[i].in[1];
			want_pwm = rows[i].in[0];
			repeat (5) @(negedge clock);
			chk("row_state", 16'(rows[i].st), 16'(state_out));
			chk("row_outs", 16'(rows[i].outs), 16'({mirror, pull, cref}));
			chk("row_boost", 16'h0, 16'({boost, sink}));
		end
		wait_st(lss_pkg::LSS_SOFT_START, DT + 8, n);
		chk("mask", 16'h3, 16'(fbm));
		chk("sinks", 16'h13, 16'({boost, sink}));
		want_pwm = 1'b0;
		repeat (4) @(negedge clock);
		chk("dim_off", 16'h0, 16'({boost, sink}));
		want_pwm = 1'b1;
		$display("test walk done");
		for (int k = 0; k < 4; k++) begin
			bring_up(k == 3);
			s_tb.in_regulation = (k == 0) ? 4'hf : 4'h0;
			s_tb.out_near_ovp = (k == 1);
			wait_st(lss_pkg::LSS_SOFT_START, DT + 8, n);
			chk("detect_len", 16'h1, 16'(n >= DT - 2 && n <= DT + 4));
			chk("ss_flag", 16'h1, 16'(ssa));
			wait_st(lss_pkg::LSS_RUN, SSE + 16, n);
			if (k < 2) begin
				chk("ss_early_end", 16'h1, 16'(n < 8));
			end else begin
				chk("ss_timer", 16'h1, 16'(n + 8 >= ((k == 3) ? SSE : SSB) && n <= ((k == 3) ? SSE : SSB) + 8));
			end
			chk("ramp_top", 16'hff, 16'(ramp));
		end
		$display("test soft start ends done");
		want_wake = 1'b0;
		repeat (SD / 2) @(negedge clock);
		chk("short_wake_low", 16'(lss_pkg::LSS_RUN), 16'(state_out));
		want_wake = 1'b1;
		repeat (4) @(negedge clock);
		want_wake = 1'b0;
		wait_st(lss_pkg::LSS_LOCKOUT, SD + 8, n);
		chk("off_delay", 16'h1, 16'(n + 4 >= SD));
		chk("mirror_off", 16'h0, 16'(mirror));
		$display("test wake shutdown done");
		for (int e = 0; e < 2; e++) begin
			bring_up(e);
			s_tb.above_low = 4'b1110;
			repeat (DT + 10) @(negedge clock);
			chk("short_hold", 16'(lss_pkg::LSS_DETECT), 16'(state_out));
			chk("short_flag", 16'h1, 16'(f_oe));
			chk("flag_level", 16'h0, 16'(f_o));
			s_tb.above_low = 4'hf;
			repeat (6) @(negedge clock);
			chk("flag_release", 16'(e == 0), 16'(f_oe));
			wait_st(lss_pkg::LSS_SOFT_START, DT + 8, n);
			chk("flag_after", 16'h0, 16'(f_oe));
		end
		$display("test pin short done");
		bring_up(0);
		s_tb.freq_pin_ok = 1'b0;
		repeat (DT + 10) @(negedge clock);
		chk("freq_hold", 16'(lss_pkg::LSS_DETECT), 16'({f_oe, state_out}));
		s_tb.freq_pin_ok = 1'b1;
		s_tb.cur_pin_ok = 1'b0;
		repeat (DT + 10) @(negedge clock);
		chk("cur_hold", 16'(lss_pkg::LSS_DETECT), 16'(state_out));
		s_tb.cur_pin_ok = 1'b1;
		wait_st(lss_pkg::LSS_SOFT_START, DT + 8, n);
		$display("test resistor pins done");
		bring_up(0);
		s_tb.out_uvp_ok = 1'b0;
		wait_st(lss_pkg::LSS_LATCHED, DT + 8, n);
		chk("latched_off", 16'h80, 16'({mirror, pull, cref, boost, sink}));
		s_tb.out_uvp_ok = 1'b1;
		repeat (SD + 10) @(negedge clock);
		chk("latch_holds", 16'(lss_pkg::LSS_LATCHED), 16'(state_out));
		want_pwm = 1'b0;
		wait_st(lss_pkg::LSS_GATE_ON, SD + 8, n);
		chk("clear_delay", 16'h1, 16'(n + 4 >= SD));
		chk("mirror_kept", 16'h1, 16'(mirror));
		$display("test latch done");
		complete_run();
	end
endmodule : test_led_driver_startup_sequencer
